/* common/osc_cfg.svh */
// Offsets, field positions, reset values and counts of the clock source block.
// Assumes byte addressing on a 32-bit APB with one register to a word.
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH

`define OSC_ADDR_W          8
`define OSC_CTRL_OFFSET     8'h00
`define OSC_TRIM_OFFSET     8'h04

`define OSC_OPT_MSB         7
`define OSC_OPT_LSB         6
`define OSC_FREQ_MSB        5
`define OSC_FREQ_LSB        4
`define OSC_RANGE_MSB       3
`define OSC_RANGE_LSB       2
`define OSC_REQ_BIT         1
`define OSC_ENGAGED_BIT     0

`define OSC_OPT_RESET       2'h0
`define OSC_FREQ_RESET      2'h2
`define OSC_RANGE_RESET     2'h0
`define OSC_TRIM_RESET      8'h80

`define OSC_CODE_RESERVED   2'h3
`define OSC_EXT_EDGES       2'h2

`endif

/* common/osc_pkg.sv */
// Types shared by the clock source block and whoever joins it.
// Assumes the constants of osc_cfg.svh for field values.
`default_nettype none
package osc_pkg;

    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_EXT_CLK  = 2'b01,
        SRC_EXT_RC   = 2'b10,
        SRC_CRYSTAL  = 2'b11
    } clock_source_t;

    typedef enum logic [2:0] {
        ST_INT    = 3'b000,
        ST_WAIT   = 3'b001,
        ST_SWITCH = 3'b010,
        ST_EXT    = 3'b011,
        ST_BACK   = 3'b100,
        ST_BACK_SW = 3'b101
    } switch_state_t;

    // Control handed to the analog internal oscillator.
    typedef struct packed {
        logic       enable;
        logic [1:0] freq_select;
        logic [7:0] trim_factor;
    } int_osc_ctrl_t;

endpackage
`default_nettype wire

/* design/osc_source_select_and_trim.sv */
// Clock source selection, external switchover and internal trim control.
// Assumes APB on pclk; oscillator levels and pins are synchronous to pclk.
`include "osc_cfg.svh"
`default_nettype none

module osc_source_select_and_trim
    import osc_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`OSC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   clock_input_pin,
    input  wire logic                   int_osc_clock,
    input  wire logic                   monitor_bypass,
    input  wire logic                   wait_mode,
    input  wire logic                   output_pin_clock_enable,
    output logic                        clock_input_pin_enable,
    output logic                        clock_output_pin_out,
    output logic                        clock_output_pin_oe,
    output logic      [2:0]             crystal_amp_enable,
    output logic                        rc_osc_enable,
    output int_osc_ctrl_t               int_osc_ctrl,
    output logic                        bus_clock_times_four,
    output logic                        bus_clock_times_two
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic [1:0]    option_reg;
    logic [1:0]    option_next;
    logic [1:0]    freq_reg;
    logic [1:0]    freq_next;
    logic [1:0]    range_reg;
    logic [1:0]    range_next;
    logic          request_reg;
    logic          request_next;
    logic [7:0]    trim_reg;
    logic [7:0]    trim_next;
    logic          engaged_reg;
    logic          engaged_next;
    logic          wr_ctrl;
    logic          wr_trim;
    logic          hit_ctrl;
    logic          hit_trim;
    logic          access;

    assign access   = psel && penable;
    assign hit_ctrl = (paddr == `OSC_CTRL_OFFSET);
    assign hit_trim = (paddr == `OSC_TRIM_OFFSET);
    assign wr_ctrl  = access && pwrite && hit_ctrl;
    assign wr_trim  = access && pwrite && hit_trim;

    // The slave never stalls, so every access completes in its first cycle.
    assign pready  = 1'b1;
    assign pslverr = access && !(hit_ctrl || hit_trim);

    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_ctrl) begin
            prdata[`OSC_OPT_MSB:`OSC_OPT_LSB]     = option_reg;
            prdata[`OSC_FREQ_MSB:`OSC_FREQ_LSB]   = freq_reg;
            prdata[`OSC_RANGE_MSB:`OSC_RANGE_LSB] = range_reg;
            prdata[`OSC_REQ_BIT]                  = request_reg;
            prdata[`OSC_ENGAGED_BIT]              = engaged_reg;
        end else if (hit_trim) begin
            prdata[7:0] = trim_reg;
        end
    end

    always_comb begin
        option_next  = option_reg;
        freq_next    = freq_reg;
        range_next   = range_reg;
        request_next = request_reg;
        trim_next    = trim_reg;
        if (wr_ctrl) begin
            option_next  = pwdata[`OSC_OPT_MSB:`OSC_OPT_LSB];
            request_next = pwdata[`OSC_REQ_BIT];
            // A reserved code would leave the oscillator undefined.
            if (pwdata[`OSC_FREQ_MSB:`OSC_FREQ_LSB] != `OSC_CODE_RESERVED)
            begin
                freq_next = pwdata[`OSC_FREQ_MSB:`OSC_FREQ_LSB];
            end
            if (pwdata[`OSC_RANGE_MSB:`OSC_RANGE_LSB] != `OSC_CODE_RESERVED)
            begin
                range_next = pwdata[`OSC_RANGE_MSB:`OSC_RANGE_LSB];
            end
        end
        if (wr_trim) begin
            trim_next = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_reg  <= `OSC_OPT_RESET;
            freq_reg    <= `OSC_FREQ_RESET;
            range_reg   <= `OSC_RANGE_RESET;
            request_reg <= 1'b0;
            trim_reg    <= `OSC_TRIM_RESET;
        end else begin
            option_reg  <= option_next;
            freq_reg    <= freq_next;
            range_reg   <= range_next;
            request_reg <= request_next;
            trim_reg    <= trim_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switchover sequencer.

    switch_state_t state_reg;
    switch_state_t state_next;
    logic [1:0]    edges_reg;
    logic [1:0]    edges_next;
    logic          sel_ext_reg;
    logic          sel_ext_next;
    logic          osc_en_reg;
    logic          osc_en_next;
    logic          ext_prev_reg;
    logic          int_prev_reg;
    logic          ext_rise;
    logic          int_rise;
    logic          req_seen;
    logic          go_back;

    assign ext_rise = clock_input_pin && !ext_prev_reg;
    assign int_rise = int_osc_clock && !int_prev_reg;
    assign req_seen = request_reg && !monitor_bypass;
    assign go_back  = !request_reg && (option_reg == SRC_INTERNAL);

    // Wait mode is deliberately not an input of any process here.
    always_comb begin
        state_next   = state_reg;
        edges_next   = edges_reg;
        sel_ext_next = sel_ext_reg;
        engaged_next = engaged_reg;
        case (state_reg)
            ST_INT: begin
                edges_next = 2'h0;
                if (req_seen && option_reg != SRC_INTERNAL) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!req_seen) begin
                    state_next = ST_INT;
                end else if (ext_rise) begin
                    edges_next = edges_reg + 2'h1;
                    if (edges_reg + 2'h1 == `OSC_EXT_EDGES) begin
                        state_next = ST_SWITCH;
                    end
                end
            end
            ST_SWITCH: begin
                // Swap only while both clocks are low so no runt pulse
                // reaches the system integration unit.
                if (!clock_input_pin && !int_osc_clock) begin
                    sel_ext_next = 1'b1;
                    engaged_next = 1'b1;
                    state_next   = ST_EXT;
                end
            end
            ST_EXT: begin
                if (go_back) begin
                    state_next = ST_BACK;
                end
            end
            ST_BACK: begin
                if (int_rise) begin
                    state_next = ST_BACK_SW;
                end
            end
            ST_BACK_SW: begin
                if (!clock_input_pin && !int_osc_clock) begin
                    sel_ext_next = 1'b0;
                    engaged_next = 1'b0;
                    state_next   = ST_INT;
                end
            end
            default: begin
                state_next   = ST_INT;
                sel_ext_next = 1'b0;
                engaged_next = 1'b0;
            end
        endcase
        // The oscillator stops one cycle after the engaged bit is set.
        osc_en_next = !(state_reg == ST_EXT && state_next == ST_EXT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= ST_INT;
            edges_reg    <= 2'h0;
            sel_ext_reg  <= 1'b0;
            engaged_reg  <= 1'b0;
            osc_en_reg   <= 1'b1;
            ext_prev_reg <= 1'b0;
            int_prev_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            edges_reg    <= edges_next;
            sel_ext_reg  <= sel_ext_next;
            engaged_reg  <= engaged_next;
            osc_en_reg   <= osc_en_next;
            ext_prev_reg <= clock_input_pin;
            int_prev_reg <= int_osc_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock outputs and pin control.

    logic x4_reg;
    logic x4_next;
    logic x2_reg;
    logic x2_next;

    always_comb begin
        x4_next = sel_ext_reg ? clock_input_pin : int_osc_clock;
        x2_next = x2_reg ^ (x4_next && !x4_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x4_reg <= 1'b0;
            x2_reg <= 1'b0;
        end else begin
            x4_reg <= x4_next;
            x2_reg <= x2_next;
        end
    end

    assign bus_clock_times_four = x4_reg;
    assign bus_clock_times_two  = x2_reg;

    assign clock_input_pin_enable = req_seen || sel_ext_reg;
    assign rc_osc_enable          = (option_reg == SRC_EXT_RC);
    assign clock_output_pin_out   = x4_reg;
    assign clock_output_pin_oe    = output_pin_clock_enable
        && (option_reg == SRC_INTERNAL || option_reg == SRC_EXT_RC);

    generate
        for (genvar i = 0; i < 3; i++) begin : g_amp
            assign crystal_amp_enable[i] = (option_reg == SRC_CRYSTAL)
                && (range_reg == 2'(i));
        end
    endgenerate

    // The analog cell scales its trim step from the selected nominal period.
    assign int_osc_ctrl.enable      = osc_en_reg;
    assign int_osc_ctrl.freq_select = freq_reg;
    assign int_osc_ctrl.trim_factor = trim_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_engage;
        state_reg == ST_SWITCH ##1 state_reg == ST_EXT;
    endsequence

    chk_engage_then_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_engage |-> engaged_reg && osc_en_reg ##1 !osc_en_reg)
        else $error("oscillator stopped before engage");

    chk_two_edges: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_reg == ST_WAIT && state_next == ST_SWITCH
            |-> ext_rise && edges_reg == 2'h1)
        else $error("switch without two external edges");

    chk_bypass_ignore: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_reg == ST_INT && monitor_bypass |=> state_reg == ST_INT)
        else $error("request honoured under bypass");

    chk_engaged_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        engaged_reg == sel_ext_reg)
        else $error("engaged bit disagrees with selection");

    chk_back_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_reg == ST_BACK_SW && state_next == ST_INT
            |=> !engaged_reg && state_reg == ST_INT)
        else $error("engaged bit not cleared on return");

    chk_reserved_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && pwdata[`OSC_FREQ_MSB:`OSC_FREQ_LSB] == 2'h3
            |=> $stable(freq_reg))
        else $error("reserved frequency code taken");

    chk_pin_forced: assert property (
        @(posedge pclk) disable iff (!presetn)
        option_reg == SRC_EXT_CLK || option_reg == SRC_CRYSTAL
            |-> !clock_output_pin_oe)
        else $error("clock pin driven in external mode");

    chk_half_rate: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(x4_reg) |-> $changed(x2_reg) ##1 $stable(x2_reg))
        else $error("x2 not toggling on x4 rise");

    chk_ext_source: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_ext_reg |=> x4_reg == $past(clock_input_pin))
        else $error("x4 not following the input pin");

endmodule
`default_nettype wire

/* tb/osc_far_side_model.sv */
// Far side of the clock source block: an external clock source on the
// input pin and the internal oscillator. Assumes the bench's pclk.
`default_nettype none
module osc_far_side_model (
    input  wire logic       pclk,
    input  wire logic       ext_run,
    input  wire logic [3:0] ext_half,
    input  wire logic       int_run,
    output logic            clock_input_pin,
    output logic            int_osc_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] ext_cnt = 4'h0;
    logic [1:0] int_cnt = 2'h0;
    ////////////////////////////////////////
    // A stopped source holds its line low; a long half period mimics a
    // slow source, so the switchover cannot lean on a quick edge.
    always @(posedge pclk) begin
        ext_cnt <= (!ext_run || ext_cnt >= ext_half) ? 4'h0 : ext_cnt + 4'h1;
        if (!ext_run) begin
            clock_input_pin <= 1'b0;
        end else if (ext_cnt >= ext_half) begin
            clock_input_pin <= !clock_input_pin;
        end
        int_cnt <= int_cnt + 2'h1;
        int_osc_clock <= int_run && int_cnt[1];
    end
endmodule
`default_nettype wire

/* tb/test_osc_source_select_and_trim.sv */
// Self-checking bench of the clock source block: APB master, far-side
// clock model, field, trim and switchover checks. Assumes 40 MHz pclk.
`include "osc_cfg.svh"
`default_nettype none
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module test_osc_source_select_and_trim
    import osc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic          pclk = 1'b0;
    logic          presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd, d, seed;
    logic          ext_run, bypass, wait_on, pin_en, cin, iclk, cin_en;
    logic          oe, pout, rc_en, x4, x2, p4, p2, pin;
    logic [1:0]    f;
    logic [2:0]    amp;
    logic [3:0]    half;
    int_osc_ctrl_t ioc;
    int            error_cnt = 0;
    int            comparisons = 0;
    int            n;
    always #12.5 pclk = ~pclk;
    osc_source_select_and_trim DUT (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .prdata                  (prdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .clock_input_pin         (cin),
        .int_osc_clock           (iclk),
        .monitor_bypass          (bypass),
        .wait_mode               (wait_on),
        .output_pin_clock_enable (pin_en),
        .clock_input_pin_enable  (cin_en),
        .clock_output_pin_out    (pout),
        .clock_output_pin_oe     (oe),
        .crystal_amp_enable      (amp),
        .rc_osc_enable           (rc_en),
        .int_osc_ctrl            (ioc),
        .bus_clock_times_four    (x4),
        .bus_clock_times_two     (x2)
    );
    osc_far_side_model far (
        .pclk            (pclk),
        .ext_run         (ext_run),
        .ext_half        (half),
        .int_run         (ioc.enable),
        .clock_input_pin (cin),
        .int_osc_clock   (iclk)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] ctl(input logic [1:0] o, fr, r,
                                        input logic q, e);
        return {24'h0, o, fr, r, q, e};
    endfunction
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Read data is taken at the edge that ends the access; the step after
    // it lets that edge's register updates land before any check.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave's answer.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic wait_eng(input logic v);
        n = 0;
        do begin
            apb(1'b0, `OSC_CTRL_OFFSET, 32'h0);
            n++;
        end while (rd[0] !== v && n < 100);
    endtask
    task automatic conclude();
        $display("Counts: %0d compared, %0d bad", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        conclude();
    end
    ////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, ext_run, bypass, wait_on} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pin_en = 1'b1;
        half = 4'h3;
        seed = 32'h0000_0034;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OSC_CTRL_OFFSET, 32'h0);
        `CHK(rd, ctl(2'h0, 2'h2, 2'h0, 1'b0, 1'b0))
        `CHK(ioc, {1'b1, 2'h2, 8'h80})
        `CHK(cin_en, 1'b0)
        apb(1'b0, `OSC_TRIM_OFFSET, 32'h0);
        `CHK(rd, {24'h0, `OSC_TRIM_RESET})
        apb(1'b1, 8'h08, xs());
        `CHK(err, 1'b1)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, `OSC_CTRL_OFFSET, ctl(2'h0, 2'h2, 2'h0, 1'b0, 1'b1));
        apb(1'b0, `OSC_CTRL_OFFSET, 32'h0);
        `CHK(rd, ctl(2'h0, 2'h2, 2'h0, 1'b0, 1'b0))
        $display("reset and map test done");
        for (int k = 0; k < 10; k++) begin
            d = (k == 0) ? 32'h0 : (k == 1) ? 32'hff : xs();
            apb(1'b1, `OSC_TRIM_OFFSET, d);
            apb(1'b0, `OSC_TRIM_OFFSET, 32'h0);
            `CHK(rd, {24'h0, d[7:0]})
            `CHK(ioc.trim_factor, d[7:0])
        end
        $display("trim test done");
        for (int c = 0; c < 4; c++) begin
            f = (c == 3) ? 2'h2 : c[1:0];
            apb(1'b1, `OSC_CTRL_OFFSET, ctl(2'h3, c[1:0], c[1:0], 1'b0, 1'b0));
            apb(1'b0, `OSC_CTRL_OFFSET, 32'h0);
            `CHK(rd, ctl(2'h3, f, f, 1'b0, 1'b0))
            `CHK(ioc.freq_select, f)
            `CHK(amp, 3'h1 << f)
        end
        for (int o = 0; o < 4; o++) begin
            apb(1'b1, `OSC_CTRL_OFFSET, ctl(o[1:0], 2'h1, 2'h1, 1'b0, 1'b0));
            `CHK(rc_en, o == 2)
            `CHK(oe, o == 0 || o == 2)
            `CHK(pout, x4)
            `CHK(amp, (o == 3) ? 3'h2 : 3'h0)
        end
        $display("field test done");
        d = xs();
        @(posedge pclk);
        half <= 4'h2 + {2'h0, d[1:0]};
        ext_run <= 1'b1;
        wait_on <= 1'b1;
        apb(1'b1, `OSC_CTRL_OFFSET, ctl(2'h1, 2'h2, 2'h0, 1'b1, 1'b0));
        `CHK(cin_en, 1'b1)
        wait_eng(1'b1);
        `CHK(rd[0], 1'b1)
        @(posedge pclk);
        #1;
        `CHK(ioc.enable, 1'b0)
        `CHK(oe, 1'b0)
        for (int k = 0; k < 24; k++) begin
            pin = cin;
            p4 = x4;
            p2 = x2;
            @(posedge pclk);
            #1;
            `CHK(x4, pin)
            `CHK(x2, (!p4 && x4) ? !p2 : p2)
        end
        apb(1'b1, `OSC_CTRL_OFFSET, ctl(2'h0, 2'h1, 2'h0, 1'b0, 1'b0));
        wait_eng(1'b0);
        `CHK(rd[0], 1'b0)
        `CHK(ioc.enable, 1'b1)
        `CHK(ioc.freq_select, 2'h1)
        `CHK(cin_en, 1'b0)
        $display("switchover test done");
        @(posedge pclk);
        bypass <= 1'b1;
        apb(1'b1, `OSC_CTRL_OFFSET, ctl(2'h1, 2'h2, 2'h0, 1'b1, 1'b0));
        repeat (40) @(posedge pclk);
        apb(1'b0, `OSC_CTRL_OFFSET, 32'h0);
        `CHK(rd[0], 1'b0)
        `CHK(cin_en, 1'b0)
        `CHK(ioc.enable, 1'b1)
        $display("bypass test done");
        conclude();
    end
endmodule
`default_nettype wire
